// *** pkg/pstab_pkg.sv ***
// package: constants for the program space table access data path
package pstab_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int PROG_WORD_W  = 24;
    localparam int DATA_W       = 16;
    localparam int BYTE_W       = 8;
    localparam int PAGE_W       = 8;
    localparam int OFFSET_W     = 16;
    localparam int MEM_ADDR_W   = 10;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int PAGE_CFG_BIT = 7;
    localparam int LOW_WORD_LSB = 0;
    localparam int HIGH_BYTE_LSB = 16;
    localparam int BYTE_SEL_BIT = 0;

    // ************************************************************
    // reset values and constants
    // ************************************************************
    localparam logic [DATA_W-1:0]      DATA_RST  = 16'h0000;
    localparam logic [BYTE_W-1:0]      PHANTOM   = 8'h00;
    localparam logic [PROG_WORD_W-1:0] WORD_RST  = 24'h000000;
    localparam logic [1:0]             PC_STEP   = 2'h2;

    // ************************************************************
    // operations
    // ************************************************************
    typedef enum logic [1:0] {
        OP_READ_LOW,
        OP_READ_HIGH,
        OP_WRITE_LOW,
        OP_WRITE_HIGH
    } pstab_op_e;

    typedef enum {
        ST_IDLE,
        ST_READ,
        ST_DONE
    } pstab_state_e;

endpackage : pstab_pkg

// *** rtl/pstab_mem.sv ***
// program memory array: 24-bit words, registered read data
module pstab_mem
    import pstab_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W
) (
    // clock
    input  wire logic                   clk,
    // read port
    input  wire logic [ADDR_W-1:0]      readAddr,
    output logic      [PROG_WORD_W-1:0] readData,
    // write port, byte lane enables for low, middle and upper byte
    input  wire logic                   writeEn,
    input  wire logic [ADDR_W-1:0]      writeAddr,
    input  wire logic [2:0]             writeLanes,
    input  wire logic [PROG_WORD_W-1:0] writeData
);

    logic [PROG_WORD_W-1:0] store [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk) begin
        if (writeEn) begin
            for (int i = 0; i < 3; i++) begin
                if (writeLanes[i]) begin
                    store[writeAddr][i*BYTE_W +: BYTE_W] <=
                        writeData[i*BYTE_W +: BYTE_W];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        readData <= store[readAddr];
    end

endmodule : pstab_mem

// *** rtl/pstab_access.sv ***
// program space table access: table reads/writes between core and memory
module pstab_access
    import pstab_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // request from the core
    input  wire logic                   reqValid,
    output logic                        reqReady,
    input  wire pstab_op_e              reqOp,
    input  wire logic                   reqByteMode,
    input  wire logic [PAGE_W-1:0]      tablePageSelect,
    input  wire logic [OFFSET_W-1:0]    reqOffset,
    input  wire logic [DATA_W-1:0]      reqWriteData,
    // read answer to the core
    output logic                        readValid,
    output logic      [DATA_W-1:0]      readData,
    // hand-off to flash programming logic
    output logic                        flashWrValid,
    output logic      [PAGE_W-1:0]      flashWrPage,
    output logic      [OFFSET_W-1:0]    flashWrOffset,
    output logic                        flashWrHigh,
    output logic                        flashWrByte,
    output logic      [DATA_W-1:0]      flashWrData,
    output logic                        flashWrConfig
);

    // ************************************************************
    // request decode
    // ************************************************************
    pstab_state_e state;
    logic         opHigh;
    logic         byteMode;
    logic         byteSel;
    logic [PROG_WORD_W-1:0] memData;
    logic [ADDR_W-1:0]      memAddr;
    logic [2:0]             lanes;
    logic [PROG_WORD_W-1:0] wrWord;
    logic                   isRead;
    logic                   isWrite;

    // page and offset form one word index; offset bit 0 is byte select,
    // so consecutive words sit two addresses apart
    function automatic logic [ADDR_W-1:0] word_index(
        input logic [PAGE_W-1:0]   page,
        input logic [OFFSET_W-1:0] off
    );
        logic [PAGE_W+OFFSET_W-2:0] full;
        full = {page, off[OFFSET_W-1:1]};
        return full[ADDR_W-1:0];
    endfunction : word_index

    assign reqReady = (state == ST_IDLE);
    assign isRead   = reqValid && reqReady &&
                      (reqOp == OP_READ_LOW || reqOp == OP_READ_HIGH);
    assign isWrite  = reqValid && reqReady &&
                      (reqOp == OP_WRITE_LOW || reqOp == OP_WRITE_HIGH);
    assign memAddr  = word_index(tablePageSelect,
                                 reqOffset);

    // ************************************************************
    // write path to the local image and flash programming logic
    // ************************************************************
    always_comb begin
        lanes  = 3'h0;
        wrWord = WORD_RST;
        if (reqOp == OP_WRITE_HIGH) begin
            // only the real upper byte is stored; phantom byte dropped
            wrWord[HIGH_BYTE_LSB +: BYTE_W] =
                reqByteMode ? reqWriteData[BYTE_W-1:0] :
                              reqWriteData[BYTE_W-1:0];
            lanes = (reqByteMode && reqOffset[BYTE_SEL_BIT]) ? 3'h0
                                                              : 3'h4;
        end else if (reqByteMode) begin
            wrWord[LOW_WORD_LSB +: DATA_W] =
                {reqWriteData[BYTE_W-1:0], reqWriteData[BYTE_W-1:0]};
            lanes = reqOffset[BYTE_SEL_BIT] ? 3'h2 : 3'h1;
        end else begin
            wrWord[LOW_WORD_LSB +: DATA_W] = reqWriteData;
            lanes = 3'h3;
        end
    end

    pstab_mem #(
        .ADDR_W     (ADDR_W)
    ) u_mem (
        .clk        (clk),
        .readAddr   (memAddr),
        .readData   (memData),
        .writeEn    (isWrite),
        .writeAddr  (memAddr),
        .writeLanes (lanes),
        .writeData  (wrWord)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            flashWrValid  <= 1'b0;
            flashWrPage   <= '0;
            flashWrOffset <= '0;
            flashWrHigh   <= 1'b0;
            flashWrByte   <= 1'b0;
            flashWrData   <= DATA_RST;
            flashWrConfig <= 1'b0;
        end else begin
            flashWrValid <= isWrite;
            if (isWrite) begin
                flashWrPage   <= tablePageSelect;
                flashWrOffset <= reqOffset;
                flashWrHigh   <= (reqOp == OP_WRITE_HIGH);
                flashWrByte   <= reqByteMode;
                flashWrData   <= reqWriteData;
                flashWrConfig <= tablePageSelect[PAGE_CFG_BIT];
            end
        end
    end

    // ************************************************************
    // read sequencing: memory read data is registered, so one wait
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (isRead) begin
                        state <= ST_READ;
                    end
                end
                ST_READ: begin
                    state <= ST_DONE;
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            opHigh   <= 1'b0;
            byteMode <= 1'b0;
            byteSel  <= 1'b0;
        end else if (isRead) begin
            opHigh   <= (reqOp == OP_READ_HIGH);
            byteMode <= reqByteMode;
            byteSel  <= reqOffset[BYTE_SEL_BIT];
        end
    end

    // ************************************************************
    // read data formatting over the two side-by-side spaces
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            readValid <= 1'b0;
            readData  <= DATA_RST;
        end else begin
            readValid <= (state == ST_READ);
            if (state == ST_READ) begin
                if (opHigh) begin
                    if (byteMode && byteSel) begin
                        readData <= DATA_RST;
                    end else begin
                        readData <= {PHANTOM,
                            memData[HIGH_BYTE_LSB +: BYTE_W]};
                    end
                end else if (byteMode) begin
                    readData <= {PHANTOM, byteSel ?
                        memData[BYTE_W +: BYTE_W] :
                        memData[0 +: BYTE_W]};
                end else begin
                    readData <= memData[LOW_WORD_LSB +: DATA_W];
                end
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_read_taken;
        isRead;
    endsequence

    // ready stays low for the two cycles of a read, then returns
    sequence s_busy_gap;
        !reqReady ##1 !reqReady ##1 reqReady;
    endsequence

    a_read_latency: assert property (
        @(posedge clk) disable iff (rst)
        s_read_taken |-> ##2 readValid)
        else $error("read answer not two cycles after request");

    a_high_phantom: assert property (
        @(posedge clk) disable iff (rst)
        readValid && opHigh |-> readData[DATA_W-1:BYTE_W] == PHANTOM)
        else $error("phantom byte of high read not zero");

    a_byte_zero: assert property (
        @(posedge clk) disable iff (rst)
        readValid && opHigh && byteMode && byteSel |->
            readData == DATA_RST)
        else $error("selected phantom byte read not zero");

    a_low_byte: assert property (
        @(posedge clk) disable iff (rst)
        readValid && !opHigh && byteMode |->
            readData[DATA_W-1:BYTE_W] == PHANTOM)
        else $error("byte read low upper byte not zero");

    // only the low space is compared; the upper program byte is not data
    a_low_word: assert property (
        @(posedge clk) disable iff (rst)
        readValid && !opHigh && !byteMode |->
            readData == $past(memData[LOW_WORD_LSB +: DATA_W]))
        else $error("word read low data mismatch");

    a_write_handoff: assert property (
        @(posedge clk) disable iff (rst)
        isWrite |=> flashWrValid && flashWrOffset == $past(reqOffset))
        else $error("write not handed to flash logic");

    a_page_space: assert property (
        @(posedge clk) disable iff (rst)
        flashWrValid |-> flashWrConfig == flashWrPage[PAGE_CFG_BIT])
        else $error("config space flag disagrees with page");

    a_busy_refuse: assert property (
        @(posedge clk) disable iff (rst)
        s_read_taken |=> s_busy_gap)
        else $error("ready not held low during read");

endmodule : pstab_access

// *** test/pstab_core_model.sv ***
// core model: issues table reads and writes to the access block
module pstab_core_model
    import pstab_pkg::*;
(
    // clock
    input  wire logic                clk,
    // request to the block
    output logic                     reqValid,
    input  wire logic                reqReady,
    output pstab_op_e                reqOp,
    output logic                     reqByteMode,
    output logic      [PAGE_W-1:0]   tablePageSelect,
    output logic      [OFFSET_W-1:0] reqOffset,
    output logic      [DATA_W-1:0]   reqWriteData,
    // answers
    input  wire logic                readValid,
    input  wire logic [DATA_W-1:0]   readData,
    input  wire logic                flashWrValid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reqValid        = 1'b0;
        reqOp           = OP_READ_LOW;
        reqByteMode     = 1'b0;
        tablePageSelect = 8'h00;
        reqOffset       = 16'h0000;
        reqWriteData    = 16'h0000;
    end

    // drives at the next rising edge; ok low if no answer in its slot
    task automatic xfer(input pstab_op_e op, input logic bm,
        input logic [7:0] pg, input logic [15:0] off,
        input logic [15:0] wd, output logic [15:0] rd, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        reqValid        <= 1'b1;
        reqOp           <= op;
        reqByteMode     <= bm;
        tablePageSelect <= pg;
        reqOffset       <= off;
        reqWriteData    <= wd;
        @(negedge clk);
        while (reqReady !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        reqValid     <= 1'b0;
        // released offset and write data show the inverse, never the old value; op, byte mode and page keep theirs
        reqOffset    <= ~off;
        reqWriteData <= ~wd;
        // a write answers right after the taken edge, a read one edge on
        if (!op[1]) begin
            @(posedge clk);
        end
        #1;
        rd = readData;
        ok = (n < 20) && (op[1] ? flashWrValid === 1'b1
                                : readValid === 1'b1);
    endtask : xfer
endmodule : pstab_core_model

// *** test/tb_top.sv ***
// testbench: table reads and writes through the core model
module tb_top
    import pstab_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reqValid, reqReady, reqByteMode, readValid, flashWrValid;
    logic flashWrHigh, flashWrByte, flashWrConfig;
    pstab_op_e reqOp;
    logic [7:0]  tablePageSelect, flashWrPage;
    logic [15:0] reqOffset, reqWriteData, readData;
    logic [15:0] flashWrOffset, flashWrData, rdSeen;
    int miscompares = 0;
    int checkCount = 0;

    always #10 clk = ~clk;

    // wide address so page bit 0 reaches the word image
    pstab_access #(.ADDR_W(16)) pstab_access_inst (.clk(clk), .rst(rst),
        .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
        .reqByteMode(reqByteMode), .tablePageSelect(tablePageSelect),
        .reqOffset(reqOffset), .reqWriteData(reqWriteData),
        .readValid(readValid), .readData(readData),
        .flashWrValid(flashWrValid), .flashWrPage(flashWrPage),
        .flashWrOffset(flashWrOffset), .flashWrHigh(flashWrHigh),
        .flashWrByte(flashWrByte), .flashWrData(flashWrData),
        .flashWrConfig(flashWrConfig));
    pstab_core_model pstab_core_model_inst (.clk(clk),
        .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
        .reqByteMode(reqByteMode), .tablePageSelect(tablePageSelect),
        .reqOffset(reqOffset), .reqWriteData(reqWriteData),
        .readValid(readValid), .readData(readData),
        .flashWrValid(flashWrValid));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic run(input pstab_op_e o, input logic bm,
        input logic [7:0] pg, input logic [15:0] off, input logic [15:0] wd);
        logic ok;
        pstab_core_model_inst.xfer(o, bm, pg, off, wd, rdSeen, ok);
        check("answer slot", 16'(ok), 16'h0001);
        if (ok !== 1'b1) begin
            finish_test();
        end
    endtask : run

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset();
        check("ready", 16'(reqReady), 16'h0001);
        check("rd valid", 16'(readValid), 16'h0000);
        check("rd data", readData, 16'h0000);
        check("wr valid", 16'(flashWrValid), 16'h0000);
        $display("test reset done");
    endtask : test_reset

    task automatic test_word();
        run(OP_WRITE_LOW, 1'b0, 8'h00, 16'h0004, 16'hA5C3);
        check("wr off", flashWrOffset, 16'h0004);
        check("wr data", flashWrData, 16'hA5C3);
        check("kind", 16'({flashWrHigh, flashWrByte}), 16'h0000);
        run(OP_WRITE_HIGH, 1'b0, 8'h00, 16'h0004, 16'h125E);
        check("wr high", 16'(flashWrHigh), 16'h0001);
        run(OP_WRITE_LOW, 1'b0, 8'h00, 16'h0006, 16'h0F0F);
        run(OP_READ_LOW, 1'b0, 8'h00, 16'h0004, 16'h0000);
        check("rd low", rdSeen, 16'hA5C3);
        run(OP_READ_HIGH, 1'b0, 8'h00, 16'h0004, 16'h0000);
        check("rd high", rdSeen, 16'h005E);
        $display("test word done");
    endtask : test_word

    task automatic test_byte();
        run(OP_READ_LOW, 1'b1, 8'h00, 16'h0004, 16'h0000);
        check("byte lo0", 16'(rdSeen[7:0]), 16'h00C3);
        run(OP_READ_LOW, 1'b1, 8'h00, 16'h0005, 16'h0000);
        check("byte lo1", 16'(rdSeen[7:0]), 16'h00A5);
        run(OP_READ_HIGH, 1'b1, 8'h00, 16'h0004, 16'h0000);
        check("byte hi0", 16'(rdSeen[7:0]), 16'h005E);
        run(OP_READ_HIGH, 1'b1, 8'h00, 16'h0005, 16'h0000);
        check("byte phantom", rdSeen, 16'h0000);
        run(OP_WRITE_HIGH, 1'b1, 8'h00, 16'h0005, 16'h00FF);
        check("wr byte", 16'(flashWrByte), 16'h0001);
        run(OP_READ_HIGH, 1'b0, 8'h00, 16'h0004, 16'h0000);
        check("phantom kept", rdSeen, 16'h005E);
        run(OP_WRITE_HIGH, 1'b1, 8'h00, 16'h0004, 16'h00A7);
        run(OP_READ_HIGH, 1'b1, 8'h00, 16'h0004, 16'h0000);
        check("byte hi write", rdSeen, 16'h00A7);
        run(OP_WRITE_LOW, 1'b1, 8'h00, 16'h0005, 16'h0011);
        run(OP_READ_LOW, 1'b0, 8'h00, 16'h0004, 16'h0000);
        check("byte write", rdSeen, 16'h11C3);
        $display("test byte done");
    endtask : test_byte

    task automatic test_page();
        run(OP_WRITE_LOW, 1'b0, 8'h01, 16'h0004, 16'h7777);
        check("wr page", 16'(flashWrPage), 16'h0001);
        check("user space", 16'(flashWrConfig), 16'h0000);
        run(OP_WRITE_LOW, 1'b0, 8'h81, 16'h0008, 16'h3C3C);
        check("cfg space", 16'(flashWrConfig), 16'h0001);
        run(OP_READ_LOW, 1'b0, 8'h00, 16'h0004, 16'h0000);
        check("page 0", rdSeen, 16'h11C3);
        run(OP_READ_LOW, 1'b0, 8'h01, 16'h0004, 16'h0000);
        check("page 1", rdSeen, 16'h7777);
        $display("test page done");
    endtask : test_page

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        test_reset();
        test_word();
        test_byte();
        test_page();
        finish_test();
    end
endmodule : tb_top
